//--- include/dram_seq_pkg.sv
// Shared types and timing constants for the page-mode DRAM access sequencer.
// Assumes a single 25 MHz system clock; all step numbers count rising edges
// after the edge on which the sequencer enters the step's state.
`default_nettype none

package dram_seq_pkg;

  // ----------------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------------
  localparam int BANK_CNT = 4;        // Banks, each with its own strobes
  localparam int BANK_W = 2;          // Bank index width (addr bits 21:20)
  localparam int CNT_W = 4;           // Internal sequencing counter width

  // ----------------------------------------------------------------------
  // Clock and precharge time
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;  // 25 MHz system clock
  localparam int PRECHARGE_NS = 80;   // Row precharge before a delayed access
  // Least time, so round up to whole cycles
  localparam int PRECHARGE_CYC = (PRECHARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [CNT_W-1:0] PRE_LAST = CNT_W'(PRECHARGE_CYC - 1);

  // ----------------------------------------------------------------------
  // Step numbers inside each access state
  // ----------------------------------------------------------------------
  localparam logic [CNT_W-1:0] WR_ACK = 4'h0;  // Early acknowledge of a write
  localparam logic [CNT_W-1:0] WR_COL = 4'h1;  // Column address selected
  localparam logic [CNT_W-1:0] WR_CAS = 4'h2;  // Column strobe ends the write
  localparam logic [CNT_W-1:0] WR_END = 4'h3;  // Back to held-row idle
  localparam logic [CNT_W-1:0] PG_COL = 4'h0;  // Page write column select
  localparam logic [CNT_W-1:0] PG_CAS = 4'h1;  // Page write column strobe
  localparam logic [CNT_W-1:0] RD_COL = 4'h0;  // Read column select
  localparam logic [CNT_W-1:0] RD_CAS = 4'h1;  // Strobe, word enable, ack
  localparam logic [CNT_W-1:0] RD_END = 4'h2;  // Read finished
  localparam logic [CNT_W-1:0] BR_COL = 4'h0;  // Refill column select
  localparam logic [CNT_W-1:0] BR_ACK = 4'h4;  // Ack between words two and three
  localparam logic [CNT_W-1:0] BR_END = 4'h8;  // Refill finished after four words

  // ----------------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,        // Plain idle, every strobe released
    ST_HELD,        // Idle with the row strobe held after a write
    ST_PRECHARGE,   // Row strobe released before a delayed access
    ST_WRITE,       // Single (or delayed) write
    ST_PAGE_WRITE,  // Fast page write on the held row
    ST_READ,        // Single (or delayed) read
    ST_BURST        // Four-word throttled refill
  } seq_state_type;

  // ----------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic rd;                  // Read strobe
    logic wr;                  // Write strobe
    logic burst;               // Block refill request with the read strobe
    logic near_write_hint;     // Write lies in the page of the previous one
    logic a22;                 // High selects space outside DRAM
    logic [BANK_W-1:0] bank;   // Address bits 21:20
  } cpu_req_type;

  typedef struct packed {
    logic [BANK_CNT-1:0] ras;  // Row strobes, one per bank, high = asserted
    logic [BANK_CNT-1:0] cas;  // Column strobes, one per bank, high = asserted
    logic col_sel;             // Address mux: 1 = column, 0 = row
  } dram_ctl_type;

  typedef struct packed {
    logic mem_ack;               // Memory acknowledge
    logic mem_read_word_enable;  // Read word enable, one per word
  } cpu_resp_type;

endpackage : dram_seq_pkg

`default_nettype wire

//--- hdl/seq_step_counter.sv
// Four-bit step counter that paces every access of the DRAM sequencer.
// Assumes clear and run come from logic on the same clock.
`default_nettype none

module seq_step_counter (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic clear,
  input wire logic run,
  output var logic [dram_seq_pkg::CNT_W-1:0] count
);
  import dram_seq_pkg::*;

  // ----------------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------------
  // Clear wins over run so each state starts at step zero
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      count <= '0;
    end else if (clear) begin
      count <= '0;
    end else if (run) begin
      count <= count + CNT_W'(1);
    end
  end

endmodule // seq_step_counter

`default_nettype wire

//--- hdl/dram_page_seq.sv
// Page-mode DRAM access sequencer: single reads, four-word refills, single,
// page and delayed writes, with the row strobe held after each write.
// Assumes processor strobes are synchronous to ref_clk and stay asserted
// until acknowledged; refresh arbitration lives outside and waits on
// cycle_in_progress.
`default_nettype none

module dram_page_seq (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire dram_seq_pkg::cpu_req_type cpu_req,
  input wire logic refresh_pending,
  output var dram_seq_pkg::dram_ctl_type dram_ctl,
  output var dram_seq_pkg::cpu_resp_type cpu_resp,
  output var logic cycle_in_progress,
  output var logic row_held_flag,
  output var logic xcvr_latch_enable
);
  import dram_seq_pkg::*;

  // ----------------------------------------------------------------------
  // State and next values
  // ----------------------------------------------------------------------
  seq_state_type state;                 // Current sequencer state
  seq_state_type next_state;
  seq_state_type pend_state;            // Access waiting behind a precharge
  seq_state_type next_pend_state;
  logic [BANK_W-1:0] bank;              // Bank of the running or held access
  logic [BANK_W-1:0] next_bank;
  dram_ctl_type next_dram_ctl;
  cpu_resp_type next_cpu_resp;
  logic next_cycle_in_progress;
  logic next_row_held_flag;
  logic next_xcvr_latch_enable;
  logic [CNT_W-1:0] step;               // Step inside the current state
  logic cnt_clear;                      // Restart the step counter
  logic cnt_run;                        // Advance the step counter

  // ----------------------------------------------------------------------
  // Request decode
  // ----------------------------------------------------------------------
  // DRAM space select
  wire logic dram_rd = cpu_req.rd && !cpu_req.a22;
  wire logic dram_wr = cpu_req.wr && !cpu_req.a22;
  wire logic dram_any = dram_rd || dram_wr;
  wire logic outside_any = (cpu_req.rd || cpu_req.wr) && cpu_req.a22;
  wire logic page_wr = dram_wr && cpu_req.near_write_hint;
  wire seq_state_type req_state = dram_wr ? ST_WRITE : (cpu_req.burst ? ST_BURST : ST_READ);

  wire logic [BANK_CNT-1:0] req_bank_hot = BANK_CNT'(1) << cpu_req.bank;
  wire logic [BANK_CNT-1:0] bank_hot = BANK_CNT'(1) << bank;

  // Refill word strobes land on odd steps up to the last word
  wire logic br_word = step[0] && (step < BR_END);

  assign cnt_run = (state != ST_IDLE);
  assign cnt_clear = (state == ST_IDLE) || (next_state != state);

  // ----------------------------------------------------------------------
  // Step counter
  // ----------------------------------------------------------------------
  seq_step_counter step_counter (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .clear(cnt_clear),
    .run(cnt_run),
    .count(step)
  );

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  // Strobes hold by default; acknowledge, word enable and latch are pulses
  always_comb begin
    next_state = state;
    next_pend_state = pend_state;
    next_bank = bank;
    next_dram_ctl = dram_ctl;
    next_cycle_in_progress = cycle_in_progress;
    next_row_held_flag = row_held_flag;
    next_cpu_resp = '0;
    next_xcvr_latch_enable = 1'b0;
    unique case (state)
      ST_IDLE: begin
        next_dram_ctl = '0;
        next_cycle_in_progress = 1'b0;
        next_row_held_flag = 1'b0;
        if (dram_any) begin
          next_cycle_in_progress = 1'b1;
          next_dram_ctl.ras = req_bank_hot;
          next_bank = cpu_req.bank;
          next_state = req_state;
        end
      end
      ST_HELD: begin
        // Column strobe of a page write drops here
        next_dram_ctl.cas = '0;
        next_dram_ctl.col_sel = 1'b0;
        if (outside_any) begin
          next_dram_ctl.ras = '0;
          next_row_held_flag = 1'b0;
          next_state = ST_IDLE;
        end else if (page_wr && !refresh_pending) begin
          // near write stays on the open row
          // busy and acknowledge on the next edge
          next_cycle_in_progress = 1'b1;
          next_cpu_resp.mem_ack = 1'b1;
          next_state = ST_PAGE_WRITE;
        end else if (dram_any) begin
          next_dram_ctl.ras = '0;
          next_cycle_in_progress = 1'b1;
          next_bank = cpu_req.bank;
          next_pend_state = req_state;
          next_state = ST_PRECHARGE;
        end else if (refresh_pending) begin
          // refresh makes it leave; precharge then idle
          next_dram_ctl.ras = '0;
          next_pend_state = ST_IDLE;
          next_state = ST_PRECHARGE;
        end
      end
      ST_PRECHARGE: begin
        if (step == PRE_LAST) begin
          if (pend_state == ST_IDLE) begin
            // Released for refresh; nothing to serve
            next_row_held_flag = 1'b0;
            next_state = ST_IDLE;
          end else begin
            next_dram_ctl.ras = bank_hot;
            next_state = pend_state;
          end
        end
      end
      ST_WRITE: begin
        // early acknowledge, data held by processor
        if (step == WR_ACK) begin
          next_cpu_resp.mem_ack = 1'b1;
        end
        if (step == WR_COL) begin
          next_dram_ctl.col_sel = 1'b1;
        end
        // column strobe on the fourth edge
        if (step == WR_CAS) begin
          next_dram_ctl.cas = bank_hot;
        end
        if (step == WR_END) begin
          // keep row, set flag, drop busy
          next_dram_ctl.cas = '0;
          next_dram_ctl.col_sel = 1'b0;
          next_cycle_in_progress = 1'b0;
          next_row_held_flag = 1'b1;
          next_state = ST_HELD;
        end
      end
      ST_PAGE_WRITE: begin
        if (step == PG_COL) begin
          next_dram_ctl.col_sel = 1'b1;
        end
        if (step == PG_CAS) begin
          // third edge closes the page write
          next_dram_ctl.cas = bank_hot;
          next_cycle_in_progress = 1'b0;
          next_state = ST_HELD;
        end
      end
      ST_READ: begin
        if (step == RD_COL) begin
          next_dram_ctl.col_sel = 1'b1;
        end
        if (step == RD_CAS) begin
          // latch the word for one cycle
          next_dram_ctl.cas = bank_hot;
          next_cpu_resp.mem_ack = 1'b1;
          next_cpu_resp.mem_read_word_enable = 1'b1;
          next_xcvr_latch_enable = 1'b1;
        end
        if (step == RD_END) begin
          // end clears row-held flag and busy
          next_dram_ctl = '0;
          next_cycle_in_progress = 1'b0;
          next_row_held_flag = 1'b0;
          next_state = ST_IDLE;
        end
      end
      ST_BURST: begin
        if (step == BR_COL) begin
          next_dram_ctl.col_sel = 1'b1;
        end
        next_dram_ctl.cas = br_word ? bank_hot : '0;
        next_cpu_resp.mem_read_word_enable = br_word;
        next_xcvr_latch_enable = br_word;
        if (step == BR_ACK) begin
          next_cpu_resp.mem_ack = 1'b1;
        end
        if (step == BR_END) begin
          // release row and busy at the end
          next_dram_ctl = '0;
          next_cycle_in_progress = 1'b0;
          next_row_held_flag = 1'b0;
          next_state = ST_IDLE;
        end
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------------
  // reset lands in plain idle
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state <= ST_IDLE;
      pend_state <= ST_IDLE;
      bank <= '0;
    end else begin
      state <= next_state;
      pend_state <= next_pend_state;
      bank <= next_bank;
    end
  end

  // ----------------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------------
  // strobes released, flags clear under reset
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      dram_ctl <= '0;
      cpu_resp <= '0;
      cycle_in_progress <= 1'b0;
      row_held_flag <= 1'b0;
      xcvr_latch_enable <= 1'b0;
    end else begin
      dram_ctl <= next_dram_ctl;
      cpu_resp <= next_cpu_resp;
      cycle_in_progress <= next_cycle_in_progress;
      row_held_flag <= next_row_held_flag;
      xcvr_latch_enable <= next_xcvr_latch_enable;
    end
  end

endmodule // dram_page_seq

`default_nettype wire

//--- verif/dram_page_seq_props.sv
// Port checker for the page-mode DRAM sequencer.
// Assumes one clock domain and an asynchronous active-low reset.
`default_nettype none

module dram_page_seq_props (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire dram_seq_pkg::cpu_req_type cpu_req,
  input wire logic refresh_pending,
  input wire dram_seq_pkg::dram_ctl_type dram_ctl,
  input wire dram_seq_pkg::cpu_resp_type cpu_resp,
  input wire logic cycle_in_progress,
  input wire logic row_held_flag,
  input wire logic xcvr_latch_enable
);
  import dram_seq_pkg::*;

  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);

  // ----------------------------------------
  // States decoded from the ports
  // ----------------------------------------
  logic [3:0] bank_oh;  // Requested bank as a strobe pattern
  logic [3:0] ras;
  logic [3:0] cas;
  logic plain_idle;  // Nothing busy, no row held
  logic held_idle;  // Row held after a write
  assign bank_oh = 4'h1 << cpu_req.bank;
  assign ras = dram_ctl.ras;
  assign cas = dram_ctl.cas;
  assign plain_idle = !cycle_in_progress && !row_held_flag && ras == 4'h0;
  // Strobe and mux off too, so the tail of a page write is not taken for idle
  assign held_idle = row_held_flag && !cycle_in_progress && ras != 4'h0 && cas == 4'h0 && !dram_ctl.col_sel;

  property p_idle_write;
    plain_idle && cpu_req.wr && !cpu_req.rd && !cpu_req.a22 |=> cycle_in_progress && ras == $past(bank_oh)
      && !row_held_flag ##1 cpu_resp.mem_ack ##2 cas == ras ##1 row_held_flag && !cycle_in_progress && ras != 4'h0;
  endproperty
  a_idle_write: assert property (p_idle_write) else $error("single write order wrong");
  property p_page_write;
    held_idle && cpu_req.wr && cpu_req.near_write_hint && !cpu_req.a22 && !refresh_pending
      |=> cycle_in_progress && cpu_resp.mem_ack ##1 dram_ctl.col_sel ##1 cas == ras && !cycle_in_progress;
  endproperty
  a_page_write: assert property (p_page_write) else $error("page write order wrong");
  property p_delayed;
    held_idle && !cpu_req.a22 && (cpu_req.rd || (cpu_req.wr && (!cpu_req.near_write_hint || refresh_pending)))
      |=> ras == 4'h0 && cycle_in_progress && row_held_flag ##1 ras == 4'h0 ##1 ras == $past(bank_oh, 3);
  endproperty
  a_delayed: assert property (p_delayed) else $error("precharge not two cycles");
  property p_outside;
    held_idle && cpu_req.a22 && (cpu_req.rd || cpu_req.wr) |=> ras == 4'h0 && !row_held_flag && !cycle_in_progress;
  endproperty
  a_outside: assert property (p_outside) else $error("row not released");
  property p_cas_pulse;
    cas != 4'h0 |=> cas == 4'h0;
  endproperty
  a_cas_pulse: assert property (p_cas_pulse) else $error("column strobe too long");
  property p_cas_bank;
    cas != 4'h0 |-> (cas & ras) == cas && $onehot(cas);
  endproperty
  a_cas_bank: assert property (p_cas_bank) else $error("strobe bank mismatch");
  property p_col_first;
    cas != 4'h0 |-> dram_ctl.col_sel && $past(dram_ctl.col_sel);
  endproperty
  a_col_first: assert property (p_col_first) else $error("mux not ahead of strobe");
  property p_latch;
    xcvr_latch_enable || cpu_resp.mem_read_word_enable |-> xcvr_latch_enable && cpu_resp.mem_read_word_enable
      && cas != 4'h0;
  endproperty
  a_latch: assert property (p_latch) else $error("latch and word enable apart");
  property p_read_end;
    cpu_resp.mem_ack && cpu_resp.mem_read_word_enable |=> !cycle_in_progress && ras == 4'h0;
  endproperty
  a_read_end: assert property (p_read_end) else $error("read did not end");
endmodule // dram_page_seq_props

bind dram_page_seq dram_page_seq_props u_props (
  .ref_clk(ref_clk),
  .nrst(nrst),
  .cpu_req(cpu_req),
  .refresh_pending(refresh_pending),
  .dram_ctl(dram_ctl),
  .cpu_resp(cpu_resp),
  .cycle_in_progress(cycle_in_progress),
  .row_held_flag(row_held_flag),
  .xcvr_latch_enable(xcvr_latch_enable)
);

`default_nettype wire

//--- verif/cpu_bus_model.sv
// Processor bus model issuing one DRAM request at a time.
// Assumes request is called just after a rising clock edge.
`default_nettype none

module cpu_bus_model (
  input wire logic ref_clk,
  input wire dram_seq_pkg::cpu_resp_type cpu_resp,
  output var dram_seq_pkg::cpu_req_type cpu_req
);
  timeunit 1ns;
  timeprecision 100ps;
  import dram_seq_pkg::*;

  // No request before the first call
  initial cpu_req = '0;

  // hold until answered
  // Unanswered requests (outside space) use a fixed hold length instead
  task automatic request(input cpu_req_type c, input int hold);
    int words;
    logic acked;
    words = 0;
    acked = 1'b0;
    cpu_req = c;
    for (int i = 1; i <= 16; i++) begin
      @(negedge ref_clk);
      if (cpu_resp.mem_read_word_enable) words++;
      if (cpu_resp.mem_ack) acked = 1'b1;
      // Reads need ack and every word enable
      if (hold > 0 ? i >= hold : acked && (c.wr || words == (c.burst ? 4 : 1))) begin
        @(posedge ref_clk);
        #1;
        // Released address lines do not keep their old value; one assignment keeps a single update per step
        cpu_req = '{rd: 1'b0, wr: 1'b0, burst: 1'b0, near_write_hint: 1'b0, a22: 1'b0, bank: ~c.bank};
        break;
      end
    end
  endtask
endmodule // cpu_bus_model

`default_nettype wire

//--- verif/dram_page_mode_access_sequencer_tb.sv
// Self-checking bench for the page-mode DRAM sequencer.
// Assumes the bus model drives requests; the checker binds itself.
`default_nettype none

module dram_page_mode_access_sequencer_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import dram_seq_pkg::*;

  logic ref_clk;
  logic nrst;
  logic refresh_pending;
  cpu_req_type cpu_req;
  dram_ctl_type dram_ctl;
  cpu_resp_type cpu_resp;
  logic cycle_in_progress;
  logic row_held_flag;
  logic xcvr_latch_enable;
  logic [13:0] snap;  // Every output in one word
  int miscompares;
  int cmp_count;
  assign snap = {dram_ctl, cpu_resp, cycle_in_progress, row_held_flag, xcvr_latch_enable};

  dram_page_seq u_dut (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .cpu_req(cpu_req),
    .refresh_pending(refresh_pending),
    .dram_ctl(dram_ctl),
    .cpu_resp(cpu_resp),
    .cycle_in_progress(cycle_in_progress),
    .row_held_flag(row_held_flag),
    .xcvr_latch_enable(xcvr_latch_enable)
  );
  cpu_bus_model u_cpu (
    .ref_clk(ref_clk),
    .cpu_resp(cpu_resp),
    .cpu_req(cpu_req)
  );

  // 25 MHz clock
  initial ref_clk = 1'b0;
  always #20 ref_clk = ~ref_clk;

  // ----------------------------------------
  // Expected outputs at edge e of an access
  // ----------------------------------------
  // Kinds: W write, P page write, R read, B refill, F refresh only, O ignored; d is the precharge shift
  function automatic logic [13:0] exp_vec(input byte k, input int e, input int d, input logic [1:0] b);
    int t;
    int n;
    logic w, p, r, ras, cas, cs, ak, cp, hd, le;
    t = e - d;
    w = k == "W";
    p = k == "P";
    r = k == "R" || k == "B";
    n = (k == "B") ? 9 : 3;
    ras = (w && t >= 1) || p || (r && t >= 1 && t <= n);
    cp = (w && t <= 4) || (p && t <= 2) || (r && t <= n);
    cs = (w && t inside {[3:4]}) || (p && t inside {[2:3]}) || (r && t >= 2 && t <= n);
    cas = (w && t == 4) || (p && t == 3) || (r && t >= 3 && t <= n && t % 2 == 1);
    ak = (w && t == 2) || (p && t == 1) || (k == "R" && t == 3) || (k == "B" && t == 6);
    hd = (w && (d > 0 || t >= 5)) || p || (r && d > 0 && t <= n) || (k == "F" && e <= 2);
    le = r && cas;
    return {ras ? 4'h1 << b : 4'h0, cas ? 4'h1 << b : 4'h0, cs, ak, le, cp, hd, le};
  endfunction

  task automatic check(input logic [13:0] got, input logic [13:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic stop_test;
    $display("comparisons %0d, miscompares %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // One access, then twelve edges compared; c is {rd, wr, burst, near, a22, bank}
  task automatic run(input byte k, input int d, input logic [6:0] c, input int hold, input logic rf);
    @(posedge ref_clk);
    #1;
    refresh_pending = rf;
    fork
      u_cpu.request(cpu_req_type'(c), hold);
    join_none
    for (int e = 1; e <= 12; e++) begin
      @(posedge ref_clk);
      #1;
      // Arbiter level is served at the first edge, so it must not linger into held-row idle
      refresh_pending = 1'b0;
      @(negedge ref_clk);
      check(snap, exp_vec(k, e, d, c[1:0]));
    end
    // Processor was answered and has let go of its strobes
    check(14'({cpu_req.rd, cpu_req.wr}), 14'h0);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    check(snap, 14'h0);
    @(posedge ref_clk);
    #1;
    nrst = 1'b1;
  endtask
  task automatic t_refused;
    run("O", 0, 7'h44, 2, 1'b0);
  endtask
  task automatic t_write_page;
    run("W", 0, 7'h21, 0, 1'b0);
    run("P", 0, 7'h29, 0, 1'b0);
    run("P", 0, 7'h29, 0, 1'b0);
  endtask
  task automatic t_delayed;
    run("W", 2, 7'h22, 0, 1'b0);
    run("R", 2, 7'h43, 0, 1'b0);
  endtask
  task automatic t_read_burst;
    run("R", 0, 7'h40, 0, 1'b0);
    run("B", 0, 7'h52, 0, 1'b0);
  endtask
  task automatic t_delayed_burst;
    run("W", 0, 7'h20, 0, 1'b0);
    run("W", 2, 7'h29, 0, 1'b1);
    run("B", 2, 7'h51, 0, 1'b0);
  endtask
  task automatic t_leave_held;
    run("W", 0, 7'h23, 0, 1'b0);
    run("O", 0, 7'h24, 2, 1'b0);
    run("W", 0, 7'h21, 0, 1'b0);
    run("F", 0, 7'h00, 1, 1'b1);
  endtask
  task automatic t_mid_reset;
    run("W", 0, 7'h22, 0, 1'b0);
    @(posedge ref_clk);
    #1;
    nrst = 1'b0;
    @(negedge ref_clk);
    check(snap, 14'h0);
    @(posedge ref_clk);
    #1;
    nrst = 1'b1;
    run("R", 0, 7'h41, 0, 1'b0);
  endtask

  initial begin
    nrst = 1'b0;
    refresh_pending = 1'b0;
    miscompares = 0;
    cmp_count = 0;
    t_reset();
    t_refused();
    t_write_page();
    t_delayed();
    t_read_burst();
    t_delayed_burst();
    t_leave_held();
    t_mid_reset();
    stop_test();
  end

  // Hang guard: the run needs far fewer cycles
  initial begin
    repeat (2000) @(posedge ref_clk);
    miscompares++;
    stop_test();
  end
endmodule // dram_page_mode_access_sequencer_tb

`default_nettype wire
